// >>> logic/image_select_consts.vh
// Constants for the remote update image select block.
// Assumes inclusion by bare name from logic/ files.
`ifndef IMAGE_SELECT_CONSTS_VH
`define IMAGE_SELECT_CONSTS_VH
// Register word offsets (byte addresses)
`define REG_CTRL 5'h00
`define REG_APP_ADDR 5'h04
`define REG_WD_TIMEOUT 5'h08
`define REG_STATUS 5'h0C
`define REG_PPTR 5'h10
// Control register bits
`define CTRL_START 0
`define CTRL_WD_EN 1
`define CTRL_WD_KICK 2
`define CTRL_FACTORY 3
// Status register bits
`define ST_USER 0
`define ST_FACTORY 1
`define ST_WD_ERR 2
`define ST_CFG_ERR 3
`define ST_SCHEME 4
// Start pointers and watchdog timeout reset value
`define SERIAL_FACTORY_PTR 24'h000000
`define PARALLEL_FACTORY_PTR 24'h010000
`define WD_TIMEOUT_RESET 24'hFFFFFF
`endif

// >>> logic/watchdog_counter.v
// User watchdog down counter.
// Assumes run_i is held low outside user mode of an application image.
`timescale 1ns/100ps
`default_nettype none
module watchdog_counter #(
   parameter W = 24
) (
   input wire clk_i,
   input wire rst_i,
   input wire run_i,
   input wire kick_i,
   input wire [W-1:0] timeout_i,
   output reg expired_o
);
   reg [W-1:0] count_q;
   always @(posedge clk_i)
   begin
      if (rst_i || !run_i)
      begin
         count_q <= timeout_i;
         expired_o <= 1'b0;
      end
      else if (count_q == {W{1'b0}})
      begin
         // Expiry wins over a kick in the same cycle; sticky until run drops
         expired_o <= 1'b1;
      end
      else if (kick_i)
      begin
         count_q <= timeout_i;
      end
      else
      begin
         count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule // watchdog_counter
`default_nettype wire

// >>> logic/remote_update_image_select.v
// Remote update image select: boot sequencer with Wishbone registers.
// Assumes a flash loader outside that reports done or error per load.
// Contract
// - After every power-up the factory image loads before any application image.
// - Serial scheme fetches the factory image from start pointer zero.
// - Parallel scheme fetches the factory image from word address 010000 hex.
// - A dedicated instruction may replace the parallel pointer for later loads.
// - Application start address may be any flash sector boundary.
// - A successful application load enters user mode.
// - On error, including watchdog expiry, fall back to the factory image.
// - Watchdog stays off in factory and during configuration; on in user mode. Here it runs in user mode only when CTRL_WD_EN was set.
//
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "image_select_consts.vh"
module remote_update_image_select #(
   parameter SECTOR_BITS = 16,
   parameter WD_W = 24
) (
   input wire clk_i,
   input wire rst_i,
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [4:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   input wire active_parallel_scheme_i,
   input wire parallel_factory_pointer_instruction_i,
   input wire [23:0] parallel_pointer_i,
   input wire load_done_i,
   input wire load_error_i,
   output reg load_start_o,
   output reg [23:0] load_addr_o,
   output wire user_mode_o,
   output wire factory_mode_o
);
   ////////////////////////////////////////////////////////////////////////
   localparam S_BOOT = 3'd0;
   localparam S_FLOAD = 3'd1;
   localparam S_FACTORY = 3'd2;
   localparam S_ALOAD = 3'd3;
   localparam S_USER = 3'd4;

   reg [2:0] state_q;
   reg [23:0] pptr_q;
   reg [23:0] app_addr_q;
   reg [WD_W-1:0] wd_timeout_q;
   reg wd_en_q;
   reg wd_err_q;
   reg cfg_err_q;
   reg start_q;
   reg reload_q;
   reg kick_q;
   wire wd_expired;
   wire req;
   wire [31:0] wmask;
   wire wr_fire;
   wire [31:0] app_merged;
   wire [31:0] wd_merged;

   assign req = cyc_i && stb_i && !ack_o;
   // Writes land on the edge where the master sees ack
   assign wr_fire = cyc_i && stb_i && we_i && ack_o;
   assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
   assign user_mode_o = (state_q == S_USER);
   assign factory_mode_o = (state_q == S_FACTORY);

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [31:0] m;
      begin
         merge = (old & ~m) | (nw & m);
      end
   endfunction

   assign app_merged = merge({8'h00, app_addr_q}, dat_i, wmask);
   assign wd_merged = merge({{(32-WD_W){1'b0}}, wd_timeout_q}, dat_i, wmask);

   ////////////////////////////////////////////////////////////////////////
   // Register access; factory-only registers ignore writes outside factory
   always @(posedge clk_i)
   begin
      start_q <= 1'b0;
      reload_q <= 1'b0;
      kick_q <= 1'b0;
      if (rst_i)
      begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
         app_addr_q <= 24'h000000;
         wd_timeout_q <= `WD_TIMEOUT_RESET;
         wd_en_q <= 1'b0;
      end
      else
      begin
         ack_o <= req;
         if (req && !we_i)
         begin
            case ({adr_i[4:2], 2'b00})
               `REG_CTRL: dat_o <= {30'h0, wd_en_q, 1'b0};
               `REG_APP_ADDR: dat_o <= {8'h00, app_addr_q};
               `REG_WD_TIMEOUT: dat_o <= {{(32-WD_W){1'b0}}, wd_timeout_q};
               `REG_STATUS: dat_o <= {27'h0, active_parallel_scheme_i, cfg_err_q,
                  wd_err_q, factory_mode_o, user_mode_o};
               `REG_PPTR: dat_o <= {8'h00, pptr_q};
               default: dat_o <= 32'h00000000;
            endcase
         end
         if (wr_fire)
         begin
            case ({adr_i[4:2], 2'b00})
               `REG_CTRL:
               begin
                  if (factory_mode_o && sel_i[0])
                  begin
                     wd_en_q <= dat_i[`CTRL_WD_EN];
                     start_q <= dat_i[`CTRL_START];
                  end
                  if (user_mode_o && sel_i[0])
                  begin
                     kick_q <= dat_i[`CTRL_WD_KICK];
                     reload_q <= dat_i[`CTRL_FACTORY];
                  end
               end
               `REG_APP_ADDR:
               begin
                  // Low bits forced to zero: only sector starts are legal
                  if (factory_mode_o)
                  begin
                     app_addr_q <= {app_merged[23:SECTOR_BITS], {SECTOR_BITS{1'b0}}};
                  end
               end
               `REG_WD_TIMEOUT:
               begin
                  if (factory_mode_o)
                  begin
                     wd_timeout_q <= wd_merged[WD_W-1:0];
                  end
               end
               default:
               begin
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Parallel pointer: replaced only through the instruction input
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pptr_q <= `PARALLEL_FACTORY_PTR;
      end
      else if (parallel_factory_pointer_instruction_i)
      begin
         pptr_q <= parallel_pointer_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   watchdog_counter #(
      .W(WD_W)
   ) u_wd (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(user_mode_o && wd_en_q),
      .kick_i(kick_q),
      .timeout_i(wd_timeout_q),
      .expired_o(wd_expired)
   );

   ////////////////////////////////////////////////////////////////////////
   // Boot sequencer; no path writes flash, so the factory image stays intact
   always @(posedge clk_i)
   begin
      load_start_o <= 1'b0;
      if (rst_i)
      begin
         state_q <= S_BOOT;
         load_addr_o <= 24'h000000;
         wd_err_q <= 1'b0;
         cfg_err_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            S_BOOT:
            begin
               load_addr_o <= active_parallel_scheme_i ? pptr_q
                  : `SERIAL_FACTORY_PTR;
               load_start_o <= 1'b1;
               state_q <= S_FLOAD;
            end
            S_FLOAD:
            begin
               if (load_done_i || load_error_i)
               begin
                  state_q <= S_FACTORY;
               end
            end
            S_FACTORY:
            begin
               if (start_q)
               begin
                  load_addr_o <= app_addr_q;
                  load_start_o <= 1'b1;
                  wd_err_q <= 1'b0;
                  cfg_err_q <= 1'b0;
                  state_q <= S_ALOAD;
               end
            end
            S_ALOAD:
            begin
               if (load_error_i)
               begin
                  cfg_err_q <= 1'b1;
                  state_q <= S_BOOT;
               end
               else if (load_done_i)
               begin
                  state_q <= S_USER;
               end
            end
            S_USER:
            begin
               if (wd_expired)
               begin
                  wd_err_q <= 1'b1;
                  state_q <= S_BOOT;
               end
               else if (reload_q)
               begin
                  state_q <= S_BOOT;
               end
            end
            default:
            begin
               state_q <= S_BOOT;
            end
         endcase
      end
   end
endmodule // remote_update_image_select
`default_nettype wire

// >>> test/image_select_sva.sv
// Checker for the image select block.
// Assumes one clock, sync reset.
`timescale 1ns/100ps
`default_nettype none
module image_select_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic load_done_i,
   input wire logic active_parallel_scheme_i,
   input wire logic parallel_factory_pointer_instruction_i,
   input wire logic [23:0] parallel_pointer_i,
   input wire logic load_start_o,
   input wire logic [23:0] load_addr_o,
   input wire logic user_mode_o,
   input wire logic factory_mode_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   reg [23:0] ptr_q;
   // Pointer copy; reset restores the default
   always @(posedge clk_i)
      if (rst_i)
         ptr_q <= 24'h010000;
      else if (parallel_factory_pointer_instruction_i)
         ptr_q <= parallel_pointer_i;
   logic fm_d1_q;
   logic fm_d2_q;
   wire logic fload;
   // Factory-mode history; a load not just after factory mode is a factory load
   always @(posedge clk_i)
   begin
      fm_d1_q <= factory_mode_o;
      fm_d2_q <= fm_d1_q;
   end
   assign fload = load_start_o && !fm_d1_q && !fm_d2_q;
   AST_ACK: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("ack late");
   AST_ACK1: assert property (ack_o |=> !ack_o)
      else $error("ack long");
   AST_BOOT: assert property ($fell(rst_i) |=> load_start_o && !user_mode_o)
      else $error("no factory load at boot");
   AST_SPTR: assert property (fload && !active_parallel_scheme_i |->
      load_addr_o == 24'h000000)
      else $error("serial pointer");
   AST_PPTR: assert property (fload && active_parallel_scheme_i |->
      load_addr_o == ptr_q)
      else $error("parallel pointer");
   AST_SECT: assert property (load_start_o && $past(factory_mode_o) |->
      load_addr_o[15:0] == 16'h0000)
      else $error("not on sector");
   AST_USER: assert property ($rose(user_mode_o) |-> $past(load_done_i))
      else $error("user without done");
   AST_EXCL: assert property (!(user_mode_o && factory_mode_o))
      else $error("two modes");
   AST_FALL: assert property ($fell(user_mode_o) |-> ##[0:2] load_start_o)
      else $error("no reload");
   AST_IDLE: assert property (user_mode_o |-> !load_start_o)
      else $error("load in user mode");
   cover property ($rose(user_mode_o));
   cover property ($fell(user_mode_o));
   cover property (load_start_o && active_parallel_scheme_i);
endmodule // image_select_sva
bind remote_update_image_select image_select_sva image_select_sva_inst (.*);
`default_nettype wire

// >>> test/flash_loader_model.sv
// Flash loader partner: answers each load 3..10 cycles after the edge that samples start.
// Assumes fail_i is set before the load it should fail.
`timescale 1ns/100ps
`default_nettype none
module flash_loader_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic fail_i,
   output logic done_o,
   output logic err_o
);
   logic [3:0] cnt_q;
   logic busy_q;
   logic bad_q;
   // Image store is read only; nothing ever written back
   always @(posedge clk_i)
   begin
      done_o <= 1'b0;
      err_o <= 1'b0;
      if (rst_i)
         busy_q <= 1'b0;
      else if (start_i)
      begin
         busy_q <= 1'b1;
         bad_q <= fail_i;
         cnt_q <= 4'h2 + 4'($urandom % 8);
      end
      else if (busy_q)
      begin
         cnt_q <= cnt_q - 4'h1;
         if (cnt_q == 4'h0)
         begin
            busy_q <= 1'b0;
            done_o <= !bad_q;
            err_o <= bad_q;
         end
      end
   end
endmodule // flash_loader_model
`default_nettype wire

// >>> test/tb_remote_update_image_select.sv
// Bench for the image select block.
// Assumes the loader model answers every load.
`timescale 1ns/100ps
`default_nettype none
module tb_remote_update_image_select;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic scheme = 1'b0, instr = 1'b0, fail = 1'b0, done, err, ack, ls, um, fm;
   logic [4:0] adr = 5'h00;
   logic [3:0] sel = 4'hF;
   logic [31:0] wd = 32'h0, rd, r;
   logic [23:0] ptr = 24'h0, la;
   logic [31:0] exp_q[$];
   integer err_total = 0, n_compared = 0;
   always #25 clk_i = ~clk_i;
   remote_update_image_select remote_update_image_select_inst (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rd),
      .ack_o(ack), .active_parallel_scheme_i(scheme),
      .parallel_factory_pointer_instruction_i(instr), .parallel_pointer_i(ptr),
      .load_done_i(done), .load_error_i(err), .load_start_o(ls), .load_addr_o(la),
      .user_mode_o(um), .factory_mode_o(fm));
   flash_loader_model flash_loader_model_inst (.clk_i(clk_i), .rst_i(rst_i), .start_i(ls),
      .fail_i(fail), .done_o(done), .err_o(err));
   task test_done;
      if (err_total == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task bad(input logic [31:0] a, input logic [31:0] b);
      err_total++;
      $display("BAD %0t %h %h", $time, a, b);
   endtask
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      integer n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      @(posedge clk_i);
      while (ack !== 1'b1 && n < 20)
      begin
         n++;
         @(posedge clk_i);
      end
      if (ack !== 1'b1)
      begin
         bad(32'h0, 32'h1);
         test_done;
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task rd_chk(input logic [4:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, $urandom);
   endtask
   // Bounded wait on the mode pins
   task wm(input logic u, input logic f);
      integer n;
      n = 0;
      while ((um !== u || fm !== f) && n < 300)
      begin
         n++;
         @(posedge clk_i);
      end
      if (um !== u || fm !== f)
      begin
         bad({30'h0, um, fm}, {30'h0, u, f});
         test_done;
      end
   endtask
   task app_reload;
      bus(1'b1, 5'h00, 32'h1);
      wm(1'b1, 1'b0);
      bus(1'b1, 5'h00, 32'h8);
      wm(1'b0, 1'b1);
   endtask
   always @(posedge clk_i)
      if (ack === 1'b1 && we === 1'b0)
      begin
         n_compared++;
         if (rd !== exp_q[0])
            bad(rd, exp_q[0]);
         void'(exp_q.pop_front());
      end
   initial
   begin
      r = $urandom(58);
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      wm(1'b0, 1'b1);
      rd_chk(5'h0C, 32'h00000002);
      bus(1'b1, 5'h10, 32'h0);
      bus(1'b1, 5'h14, 32'h5);
      rd_chk(5'h10, 32'h00010000);
      rd_chk(5'h14, 32'h00000000);
      r = $urandom;
      bus(1'b1, 5'h04, r);
      rd_chk(5'h04, {8'h00, r[23:16], 16'h0000});
      // Lane 2 only: other bytes of the write must be dropped
      sel <= 4'h4;
      bus(1'b1, 5'h04, 32'hFFAB5A5A);
      sel <= 4'hF;
      rd_chk(5'h04, 32'h00AB0000);
      bus(1'b1, 5'h08, 32'h8);
      rd_chk(5'h08, 32'h00000008);
      fail <= 1'b1;
      bus(1'b1, 5'h00, 32'h3);
      wm(1'b0, 1'b0);
      repeat (2) @(posedge clk_i);
      fail <= 1'b0;
      wm(1'b0, 1'b1);
      rd_chk(5'h0C, 32'h0000000A);
      bus(1'b1, 5'h00, 32'h3);
      wm(1'b1, 1'b0);
      rd_chk(5'h0C, 32'h00000001);
      repeat (5) bus(1'b1, 5'h00, 32'h4);
      rd_chk(5'h0C, 32'h00000001);
      wm(1'b0, 1'b1);
      rd_chk(5'h0C, 32'h00000006);
      repeat (40) @(posedge clk_i);
      rd_chk(5'h0C, 32'h00000006);
      app_reload;
      rd_chk(5'h0C, 32'h00000002);
      // Mid-run reset into the parallel scheme
      scheme <= 1'b1;
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      wm(1'b0, 1'b1);
      rd_chk(5'h0C, 32'h00000012);
      ptr <= 24'($urandom);
      instr <= 1'b1;
      @(posedge clk_i);
      instr <= 1'b0;
      rd_chk(5'h10, {8'h00, ptr});
      app_reload;
      rd_chk(5'h0C, 32'h00000012);
      test_done;
   end
endmodule // tb_remote_update_image_select
`default_nettype wire
